// file: hw/mpi_defines.svh
// constants for the media independent port wrapper
`ifndef MPI_DEFINES_SVH
`define MPI_DEFINES_SVH
`define MPI_CLK_NS 100
`define MPI_HALF_1000_NS 4
`define MPI_HALF_100_NS 20
`define MPI_HALF_10_NS 200
`define MPI_HALF_REF_NS 10
`define MPI_HALF_CYC(ns) 8'((((ns) / `MPI_CLK_NS) > 0) ? ((ns) / `MPI_CLK_NS) : 1)
`define MPI_RMII_HOLD 4'h9
`define MPI_NIB_UNITS 3'h2
`define MPI_DIB_UNITS 3'h4
`define MPI_FIFO_DEPTH 8
`endif

// file: hw/mpi_pkg.sv
// types shared by the media independent port wrapper
`default_nettype none
package mpi_pkg;
  typedef enum logic [1:0] {MPI_MII, MPI_RMII, MPI_RGMII} mpi_mode_t;
  typedef enum logic [1:0] {MPI_S10, MPI_S100, MPI_S1000} mpi_speed_t;
  typedef enum logic {MPI_TX_IDLE, MPI_TX_SEND} mpi_tx_state_t;
  typedef struct packed {
    logic       err;
    logic       last;
    logic [7:0] data;
  } mpi_byte_t;
  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] d;
  } mpi_txpin_t;
  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] d;
  } mpi_rxpin_t;
  typedef struct packed {
    logic       tx_clk;
    logic       rx_clk;
    mpi_rxpin_t pins;
  } mpi_pinsync_t;
endpackage
`default_nettype wire

// file: hw/mpi_port.sv
// per-port xmii wrapper with transmit fifo
`include "mpi_defines.svh"
`default_nettype none

module mpi_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = `MPI_FIFO_DEPTH
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_data,
  output var  logic         wr_ready,
  output var  logic         rd_valid,
  output var  logic [W-1:0] rd_data,
  input  wire logic         rd_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0]   count;
  logic [AW:0]   next_count;
  logic          push;
  logic          pop;

  assign push    = wr_valid & wr_ready;
  assign pop     = rd_valid & rd_ready;
  assign rd_data = mem[rptr];

  always_comb begin
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wptr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wptr     <= '0;
      rptr     <= '0;
      count    <= '0;
      wr_ready <= 1'b1;
      rd_valid <= 1'b0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
      end
      count    <= next_count;
      wr_ready <= next_count != (AW+1)'(DEPTH);
      rd_valid <= next_count != '0;
    end
  end
endmodule // mpi_fifo

module mpi_port (
  input  wire logic               clk_sys,
  input  wire logic               arst_n,
  input  wire mpi_pkg::mpi_mode_t  cfg_mode,
  input  wire logic               cfg_mac_to_mac,
  input  wire mpi_pkg::mpi_speed_t cfg_speed,
  input  wire mpi_pkg::mpi_byte_t  tx_in,
  input  wire logic               tx_in_valid,
  output var  logic               tx_in_ready,
  output var  mpi_pkg::mpi_byte_t  rx_out,
  output var  logic               rx_out_valid,
  output var  logic               tx_active,
  output var  logic               rx_active,
  input  wire logic               tx_clk_in,
  output var  logic               tx_clk_out,
  output var  logic               tx_clk_oe_n,
  input  wire logic               rx_clk_in,
  output var  logic               rx_clk_out,
  output var  logic               rx_clk_oe_n,
  output var  mpi_pkg::mpi_txpin_t tx_pins,
  input  wire mpi_pkg::mpi_rxpin_t rx_pins
);
  import mpi_pkg::*;

  function automatic logic [2:0] units_per_byte(input mpi_mode_t m);
    return (m == MPI_RMII) ? `MPI_DIB_UNITS : `MPI_NIB_UNITS;
  endfunction

  function automatic logic [3:0] low_unit(input mpi_mode_t m, input logic [7:0] b);
    return (m == MPI_RMII) ? {2'h0, b[1:0]} : b[3:0];
  endfunction

  function automatic logic [7:0] shift_out(input mpi_mode_t m, input logic [7:0] b);
    return (m == MPI_RMII) ? {2'h0, b[7:2]} : {4'h0, b[7:4]};
  endfunction

  logic [1:0]   rst_pipe;
  logic         rst_n;
  mpi_pinsync_t s1;
  mpi_pinsync_t s2;
  logic         is_rmii;
  logic         is_rgmii;
  logic         slow_rmii;
  logic         drive_tx;
  logic         drive_rx;
  logic [7:0]   half_len;
  logic [7:0]   half_cnt;
  logic         gen_clk;
  logic         tx_lvl;
  logic         rx_lvl;
  logic         tx_lvl_q;
  logic         rx_lvl_q;
  logic         tx_pos;
  logic         tx_neg;
  logic         rx_pos;
  logic         rx_neg;
  logic         tx_tick;
  logic         rx_tick;
  logic         fifo_valid;
  logic [9:0]   fifo_word;
  mpi_byte_t    fifo_byte;
  logic         pop;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // pin inputs pass two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= {tx_clk_in, rx_clk_in, rx_pins};
      s2 <= s1;
    end
  end

  assign is_rmii   = cfg_mode == MPI_RMII;
  assign is_rgmii  = cfg_mode == MPI_RGMII;
  assign slow_rmii = is_rmii && (cfg_speed == MPI_S10);

  assign drive_tx = is_rgmii || (is_rmii ? !cfg_mac_to_mac : cfg_mac_to_mac);
  assign drive_rx = cfg_mac_to_mac && !is_rmii;

  always_comb begin
    if (is_rmii) begin
      half_len = `MPI_HALF_CYC(`MPI_HALF_REF_NS);
    end else if (is_rgmii && cfg_speed == MPI_S1000) begin
      half_len = `MPI_HALF_CYC(`MPI_HALF_1000_NS);
    end else if (cfg_speed == MPI_S10) begin
      half_len = `MPI_HALF_CYC(`MPI_HALF_10_NS);
    end else begin
      half_len = `MPI_HALF_CYC(`MPI_HALF_100_NS);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt <= 8'h00;
      gen_clk  <= 1'b0;
    end else if (half_cnt == 8'h00) begin
      half_cnt <= half_len - 8'h01;
      gen_clk  <= ~gen_clk;
    end else begin
      half_cnt <= half_cnt - 8'h01;
    end
  end

  // rmii both ways on one clock
  assign tx_lvl = drive_tx ? gen_clk : s2.tx_clk;
  assign rx_lvl = is_rmii ? tx_lvl : (drive_rx ? gen_clk : s2.rx_clk);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_lvl_q    <= 1'b0;
      rx_lvl_q    <= 1'b0;
      tx_clk_out  <= 1'b0;
      rx_clk_out  <= 1'b0;
      tx_clk_oe_n <= 1'b1;
      rx_clk_oe_n <= 1'b1;
    end else begin
      tx_lvl_q    <= tx_lvl;
      rx_lvl_q    <= rx_lvl;
      tx_clk_out  <= gen_clk;
      rx_clk_out  <= gen_clk;
      tx_clk_oe_n <= ~drive_tx;
      rx_clk_oe_n <= ~drive_rx;
    end
  end

  assign tx_pos  = tx_lvl & ~tx_lvl_q;
  assign tx_neg  = ~tx_lvl & tx_lvl_q;
  assign rx_pos  = rx_lvl & ~rx_lvl_q;
  assign rx_neg  = ~rx_lvl & rx_lvl_q;
  assign tx_tick = is_rgmii ? (tx_pos | tx_neg) : tx_pos;
  assign rx_tick = is_rgmii ? (rx_pos | rx_neg) : rx_pos;

  mpi_fifo #(.W(10), .DEPTH(`MPI_FIFO_DEPTH)) u_tx_fifo (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .wr_valid (tx_in_valid),
    .wr_data  (tx_in),
    .wr_ready (tx_in_ready),
    .rd_valid (fifo_valid),
    .rd_data  (fifo_word),
    .rd_ready (pop)
  );
  assign fifo_byte = mpi_byte_t'(fifo_word);

  mpi_tx_state_t state;
  mpi_tx_state_t next_state;
  logic [7:0]    shreg;
  logic [7:0]    next_shreg;
  logic [2:0]    left;
  logic [2:0]    next_left;
  logic [3:0]    hold;
  logic [3:0]    next_hold;
  logic          cur_v;
  logic          next_v;
  logic          cur_e;
  logic          next_e;
  logic          cur_last;
  logic          next_last;
  logic [3:0]    cur_d;
  logic [3:0]    next_d;

  always_comb begin
    pop        = 1'b0;
    next_state = state;
    next_shreg = shreg;
    next_left  = left;
    next_hold  = hold;
    next_v     = cur_v;
    next_e     = cur_e;
    next_last  = cur_last;
    next_d     = cur_d;
    if (tx_tick) begin
      if (state == MPI_TX_SEND && hold != 4'h0) begin
        next_hold = hold - 4'h1;
      end else if (state == MPI_TX_SEND && left != 3'h0) begin
        next_d     = low_unit(cfg_mode, shreg);
        next_shreg = shift_out(cfg_mode, shreg);
        next_left  = left - 3'h1;
        next_hold  = slow_rmii ? `MPI_RMII_HOLD : 4'h0;
      end else if (!is_rgmii || tx_pos) begin
        if (fifo_valid && !(state == MPI_TX_SEND && cur_last)) begin
          pop        = 1'b1;
          next_d     = low_unit(cfg_mode, fifo_byte.data);
          next_shreg = shift_out(cfg_mode, fifo_byte.data);
          next_left  = units_per_byte(cfg_mode) - 3'h1;
          next_hold  = slow_rmii ? `MPI_RMII_HOLD : 4'h0;
          next_v     = 1'b1;
          next_e     = fifo_byte.err;
          next_last  = fifo_byte.last;
          next_state = MPI_TX_SEND;
        end else begin
          next_v     = 1'b0;
          next_e     = 1'b0;
          next_last  = 1'b0;
          next_d     = 4'h0;
          next_state = MPI_TX_IDLE;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state    <= MPI_TX_IDLE;
      shreg    <= 8'h00;
      left     <= 3'h0;
      hold     <= 4'h0;
      cur_v    <= 1'b0;
      cur_e    <= 1'b0;
      cur_last <= 1'b0;
      cur_d    <= 4'h0;
    end else begin
      case (state)
        MPI_TX_IDLE, MPI_TX_SEND: begin
          state <= next_state;
        end
        default: begin
          state <= MPI_TX_IDLE;
        end
      endcase
      shreg    <= next_shreg;
      left     <= next_left;
      hold     <= next_hold;
      cur_v    <= next_v;
      cur_e    <= next_e;
      cur_last <= next_last;
      cur_d    <= next_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_pins   <= '0;
      tx_active <= 1'b0;
    end else begin
      tx_active <= next_state == MPI_TX_SEND;
      if (tx_tick) begin
        // nibble or pair on data pins
        tx_pins.d  <= next_d;
        // falling ctl is valid xor error
        tx_pins.en <= (is_rgmii && tx_neg) ? (next_v ^ next_e) : next_v;
        tx_pins.er <= is_rgmii ? 1'b0 : (next_v & next_e);
      end
    end
  end

  logic       ctl_pos;
  logic [3:0] rx_hold;
  logic [7:0] acc;
  logic [2:0] cnt;
  logic       acc_err;
  mpi_byte_t  pend;
  logic       pend_valid;
  logic       samp;
  logic       samp_dv;
  logic       samp_er;
  logic [7:0] next_acc;

  assign samp_dv = is_rgmii ? (rx_pos ? s2.pins.dv : ctl_pos) : s2.pins.dv;
  assign samp_er = is_rgmii ? (rx_neg & (s2.pins.dv ^ ctl_pos)) : s2.pins.er;
  assign samp    = rx_tick && (rx_hold == 4'h0);
  assign next_acc = is_rmii ? {s2.pins.d[1:0], acc[7:2]} : {s2.pins.d, acc[7:4]};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_pos      <= 1'b0;
      rx_hold      <= 4'h0;
      acc          <= 8'h00;
      cnt          <= 3'h0;
      acc_err      <= 1'b0;
      pend         <= '0;
      pend_valid   <= 1'b0;
      rx_out       <= '0;
      rx_out_valid <= 1'b0;
      rx_active    <= 1'b0;
    end else begin
      rx_out_valid <= 1'b0;
      if (rx_tick && rx_pos) begin
        ctl_pos <= s2.pins.dv;
      end
      if (rx_tick && rx_hold != 4'h0) begin
        rx_hold <= rx_hold - 4'h1;
      end
      if (samp && samp_dv) begin
        rx_active <= 1'b1;
        rx_hold   <= slow_rmii ? `MPI_RMII_HOLD : 4'h0;
        if (cnt + 3'h1 == units_per_byte(cfg_mode)) begin
          cnt          <= 3'h0;
          acc_err      <= 1'b0;
          pend         <= '{err: acc_err | samp_er, last: 1'b0, data: next_acc};
          pend_valid   <= 1'b1;
          rx_out       <= '{err: pend.err, last: 1'b0, data: pend.data};
          rx_out_valid <= pend_valid;
        end else begin
          acc     <= next_acc;
          cnt     <= cnt + 3'h1;
          acc_err <= acc_err | samp_er;
        end
      end else if (samp && (!is_rgmii || rx_pos)) begin
        rx_active    <= 1'b0;
        rx_hold      <= 4'h0;
        cnt          <= 3'h0;
        acc_err      <= 1'b0;
        pend_valid   <= 1'b0;
        rx_out       <= '{err: pend.err, last: 1'b1, data: pend.data};
        rx_out_valid <= pend_valid;
      end
    end
  end
endmodule // mpi_port

`default_nettype wire

// file: hw/mpi_port_unused_note.sv
// intentionally empty unit kept for compile order
`default_nettype none
`default_nettype wire

// file: tb/mpi_port_checker.sv
// assertions on the port wrapper pins
`default_nettype none
module mpi_port_checker (
  input wire logic                clk_sys,
  input wire logic                arst_n,
  input wire mpi_pkg::mpi_mode_t  cfg_mode,
  input wire logic                cfg_mac_to_mac,
  input wire mpi_pkg::mpi_speed_t cfg_speed,
  input wire mpi_pkg::mpi_txpin_t tx_pins,
  input wire logic                tx_active,
  input wire logic                tx_clk_oe_n,
  input wire logic                rx_clk_oe_n,
  input wire logic                rx_out_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  import mpi_pkg::*;
  logic       own_tx;
  logic       own_rx;
  logic [7:0] hold;
  assign own_tx = cfg_mode == MPI_RGMII || (cfg_mode == MPI_MII && cfg_mac_to_mac)
                  || (cfg_mode == MPI_RMII && !cfg_mac_to_mac);
  assign own_rx = cfg_mac_to_mac && cfg_mode != MPI_RMII;
  // cycles since the data lines last moved
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) hold <= 8'h00;
    else if ($changed(tx_pins.d)) hold <= 8'h00;
    else if (hold != 8'hFF) hold <= hold + 8'h01;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  chk_tx_clk_owner: assert property (arst_n [*4] |-> tx_clk_oe_n == !own_tx)
    else $error("tx clock drive wrong");
  chk_rx_clk_owner: assert property (arst_n [*4] |-> rx_clk_oe_n == !own_rx)
    else $error("rx clock drive wrong");
  chk_rmii_pair_only: assert property (cfg_mode == MPI_RMII |-> tx_pins.d[3:2] == 2'h0)
    else $error("rmii upper data bits set");
  chk_rgmii_no_er: assert property (cfg_mode == MPI_RGMII |-> !tx_pins.er)
    else $error("rgmii drives error line");
  chk_en_marks_frame: assert property (cfg_mode != MPI_RGMII |-> tx_pins.en == tx_active)
    else $error("enable not matching frame");
  chk_idle_quiet: assert property (!tx_active |-> tx_pins == '0)
    else $error("pins busy outside frame");
  chk_rx_one_pulse: assert property (rx_out_valid |=> !rx_out_valid)
    else $error("receive strobe too long");
  chk_rmii_slow_hold: assert property (cfg_mode == MPI_RMII && cfg_speed == MPI_S10
    && $changed(tx_pins.d) && $past(tx_active) |-> hold >= 8'h13)
    else $error("rmii slow pair too short");
endmodule // mpi_port_checker
bind mpi_port mpi_port_checker u_chk (.clk_sys, .arst_n, .cfg_mode, .cfg_mac_to_mac, .cfg_speed, .tx_pins,
  .tx_active, .tx_clk_oe_n, .rx_clk_oe_n, .rx_out_valid);
`default_nettype wire

// file: tb/mpi_peer.sv
// far side phy or mac model for the port wrapper
`default_nettype none
module mpi_peer (
  input  wire logic                clk_sys,
  input  wire mpi_pkg::mpi_mode_t  cfg_mode,
  input  wire mpi_pkg::mpi_speed_t cfg_speed,
  input  wire logic                stall,
  input  wire logic                tx_clk_out,
  input  wire logic                tx_clk_oe_n,
  input  wire logic                rx_clk_out,
  input  wire logic                rx_clk_oe_n,
  output var  logic                tx_clk_in,
  output var  logic                rx_clk_in,
  output var  mpi_pkg::mpi_rxpin_t rx_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  import mpi_pkg::*;
  logic       pclk = 1'h0;
  logic       lk_q = 1'h0;
  logic       lk;
  logic [1:0] pcnt = 2'h0;
  logic [3:0] hcnt = 4'h0;
  mpi_rxpin_t q[$];
  assign tx_clk_in = tx_clk_oe_n ? pclk : tx_clk_out;
  assign rx_clk_in = rx_clk_oe_n ? pclk : rx_clk_out;
  assign lk = cfg_mode == MPI_RMII ? tx_clk_in : rx_clk_in;
  initial rx_pins = '0;
  always @(posedge clk_sys) begin
    if (!stall) begin
      pcnt <= pcnt + 2'h1;
      if (pcnt == 2'h3) pclk <= !pclk;
    end
    lk_q <= lk;
    // rgmii on both edges with frames opening on falling, other modes on rising only
    if (lk != lk_q && (lk || cfg_mode == MPI_RGMII)) begin
      if (hcnt != 4'h0) hcnt <= hcnt - 4'h1;
      else if (q.size() > 0 && (rx_pins.dv || cfg_mode != MPI_RGMII || !lk)) begin
        rx_pins <= q.pop_front();
        hcnt <= (cfg_mode == MPI_RMII && cfg_speed == MPI_S10) ? 4'h9 : 4'h0;
      end else rx_pins <= '{dv: 1'h0, er: 1'h0, d: ~rx_pins.d};
    end
  end
  task automatic put(input logic [7:0] b);
    if (cfg_mode == MPI_RMII)
      for (int i = 0; i < 4; i++) q.push_back('{1'h1, 1'h0, {2'h0, b[2*i +: 2]}});
    else begin
      q.push_back('{1'h1, 1'h0, b[3:0]});
      q.push_back('{1'h1, 1'h0, b[7:4]});
    end
  endtask
endmodule // mpi_peer
`default_nettype wire

// file: tb/mpi_port_tb.sv
// self-checking bench for the port wrapper
`default_nettype none
module mpi_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mpi_pkg::*;
  logic       clk_sys = 1'h0, arst_n = 1'h0, cfg_mac_to_mac = 1'h0, stall = 1'h0, tx_in_valid = 1'h0;
  logic       tx_in_ready, rx_out_valid, tx_active, rx_active, tx_clk_in, tx_clk_out, tx_clk_oe_n;
  logic       rx_clk_in, rx_clk_out, rx_clk_oe_n;
  mpi_mode_t  cfg_mode = MPI_MII;
  mpi_speed_t cfg_speed = MPI_S100;
  mpi_byte_t  tx_in = '0, rx_out, got_q[$];
  mpi_txpin_t tx_pins, tx_prev = '0, log_q[$];
  mpi_rxpin_t rx_pins;
  int         n_mismatch = 0, checks = 0;
  logic [7:0] pat [3] = '{8'h79, 8'h9E, 8'hE7};
  mpi_port dut (.clk_sys, .arst_n, .cfg_mode, .cfg_mac_to_mac, .cfg_speed, .tx_in, .tx_in_valid, .tx_in_ready,
    .rx_out, .rx_out_valid, .tx_active, .rx_active, .tx_clk_in, .tx_clk_out, .tx_clk_oe_n, .rx_clk_in,
    .rx_clk_out, .rx_clk_oe_n, .tx_pins, .rx_pins);
  mpi_peer peer (.clk_sys, .cfg_mode, .cfg_speed, .stall, .tx_clk_out, .tx_clk_oe_n, .rx_clk_out,
    .rx_clk_oe_n, .tx_clk_in, .rx_clk_in, .rx_pins);
  always #50 clk_sys = !clk_sys;
  // log of every distinct pin state and received byte
  always @(posedge clk_sys) begin
    if (tx_pins !== tx_prev) log_q.push_back(tx_pins);
    tx_prev <= tx_pins;
    if (rx_out_valid === 1'h1) got_q.push_back(rx_out);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic setup(input mpi_mode_t m, input logic mm, input mpi_speed_t s);
    arst_n <= 1'h0;
    cfg_mode <= m;
    cfg_mac_to_mac <= mm;
    cfg_speed <= s;
    repeat (3) @(posedge clk_sys);
    check(16'({tx_in_ready, tx_clk_oe_n, rx_clk_oe_n, tx_active, rx_out_valid, tx_pins}), 16'({3'h7, 8'h00}));
    check(16'(rx_active), 16'h0000);
    arst_n <= 1'h1;
    repeat (6) @(posedge clk_sys);
    check(16'({tx_clk_oe_n, rx_clk_oe_n}), 16'({!(m == MPI_RGMII || (m == MPI_MII && mm) || (m == MPI_RMII && !mm)),
      !(mm && m != MPI_RMII)}));
  endtask
  task automatic tx_expect(input int n, input int e);
    mpi_txpin_t x;
    int         j;
    for (int t = 0; t < 3000 && !(log_q.size() > 1 && tx_active === 1'h0); t++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    j = 0;
    for (int i = 0; i < n; i++)
      for (int k = 0; k < (cfg_mode == MPI_RMII ? 4 : 2); k++) begin
        x.d = cfg_mode == MPI_RMII ? {2'h0, pat[i % 3][2*k +: 2]} : pat[i % 3][4*k +: 4];
        x.en = !(cfg_mode == MPI_RGMII && k == 1 && i == e);
        x.er = cfg_mode != MPI_RGMII && i == e;
        check(16'(log_q[j]), 16'(x));
        j++;
      end
    check(16'(log_q[j]), 16'h0000);
    check(16'(log_q.size()), 16'(j + 1));
  endtask
  task automatic tx_frame(input int n, input int e);
    log_q.delete();
    for (int i = 0; i < n; i++) begin
      tx_in <= '{err: i == e, last: i == n - 1, data: pat[i % 3]};
      tx_in_valid <= 1'h1;
      @(posedge clk_sys);
      while (tx_in_ready !== 1'h1) @(posedge clk_sys);
    end
    tx_in_valid <= 1'h0;
    tx_expect(n, e);
  endtask
  task automatic fill();
    int k;
    k = 0;
    stall <= 1'h1;
    log_q.delete();
    repeat (4) @(posedge clk_sys);
    tx_in_valid <= 1'h1;
    repeat (12) begin
      tx_in <= '{err: 1'h0, last: k == 7, data: pat[k % 3]};
      @(posedge clk_sys);
      if (tx_in_ready === 1'h1) k++;
    end
    check(16'(k), 16'h0008);
    tx_in_valid <= 1'h0;
    stall <= 1'h0;
    tx_expect(8, -1);
    check(16'(tx_in_ready), 16'h0001);
  endtask
  task automatic rx_frame();
    got_q.delete();
    for (int i = 0; i < 3; i++) peer.put(pat[i]);
    for (int t = 0; t < 2000 && got_q.size() < 1; t++) @(posedge clk_sys);
    check(16'(rx_active), 16'h0001);
    for (int t = 0; t < 2000 && got_q.size() < 3; t++) @(posedge clk_sys);
    check(16'(got_q.size()), 16'h0003);
    check(16'(rx_active), 16'h0000);
    for (int i = 0; i < 3; i++) check(16'(got_q[i]), 16'({1'h0, i == 2, pat[i]}));
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    setup(MPI_MII, 1'h0, MPI_S100);
    tx_frame(3, 1);
    rx_frame();
    fill();
    setup(MPI_MII, 1'h1, MPI_S10);
    tx_frame(3, 1);
    setup(MPI_RMII, 1'h0, MPI_S10);
    tx_frame(3, 1);
    setup(MPI_RMII, 1'h1, MPI_S100);
    tx_frame(3, 1);
    rx_frame();
    setup(MPI_RGMII, 1'h0, MPI_S1000);
    tx_frame(3, 1);
    rx_frame();
    setup(MPI_RGMII, 1'h1, MPI_S100);
    tx_frame(3, 2);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    finish_test();
  end
endmodule // mpi_port_tb
`default_nettype wire
